// ===== verilog/brownout_monitor_control.v
// The APB interface to the registers is this design's own decision.
`include "brownout_consts.vh"

module brownout_monitor_control #(
  parameter FAST_CYCLES = `SAMPLE_FAST_CYCLES,
  parameter SLOW_CYCLES = `SAMPLE_SLOW_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // configuration fuse; active mode and threshold caught while rst is high, sleep mode and sample rate in the first cycle after
  input  wire [1:0]  fuse_active_mode,
  input  wire [1:0]  fuse_sleep_mode,
  input  wire        fuse_sample_rate,
  input  wire [2:0]  fuse_threshold_code,
  // power state
  input  wire        deep_sleep,
  input  wire        monitor_ready,
  // comparator, asynchronous
  input  wire        supply_below_warning,
  // analog control
  output reg  [1:0]  monitor_mode,
  output reg         monitor_enable,
  output reg         monitor_sampled,
  output reg         sample_strobe,
  output reg  [2:0]  threshold_code,
  output reg  [1:0]  warning_margin_code,
  output reg         wake_stall,
  // interrupt
  output reg         warning_irq
);

  // register state
  reg  [1:0] active_mode_reg;
  reg  [1:0] sleep_mode_reg;
  reg  [1:0] sleep_mode_next;
  reg        sample_rate_select_reg;
  reg        sample_rate_select_next;
  reg  [2:0] threshold_code_reg;
  reg  [1:0] warning_margin_code_reg;
  reg  [1:0] warning_direction_select_reg;
  reg        warning_irq_enable_reg;
  reg        warning_irq_flag_reg;
  reg        warning_irq_flag_next;
  reg        warning_state_bit_reg;
  reg  [2:0] unlock_cnt_reg;
  reg        seen_reg;
  reg  [2:0] unlock_cnt_next;
  reg [31:0] rdata_next;

  // bus decode
  wire       setup_ph;
  wire       access_ph;
  wire       wr;
  wire [7:0] idx;
  wire       mapped;
  wire       lane0;
  wire       unlocked;
  wire       wr_mode;
  wire       wr_level;
  wire       wr_irq_ctrl;
  wire       wr_flag;
  wire       wr_unlock;

  // monitor path
  wire       below_sync;
  wire       tick;
  wire [1:0] cur_mode;
  wire       mon_on;
  wire       mon_samp;
  wire       take;
  wire       fell;
  wire       rose;
  reg        cross_hit;

  function is_reg;
    input [7:0] a;
    input [7:0] i;
    begin
      is_reg = (a[1:0] == 2'h0) && (a[7:2] == i[5:0]);
    end
  endfunction

  function known_idx;
    input [7:0] i;
    begin
      known_idx = (i == `IDX_MODE_CTRL) || (i == `IDX_THRESHOLD) ||
                  (i == `IDX_WARN_LEVEL) || (i == `IDX_IRQ_CTRL) ||
                  (i == `IDX_IRQ_FLAG) || (i == `IDX_WARN_STATE) ||
                  (i == `IDX_UNLOCK);
    end
  endfunction

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr        = access_ph && pwrite && lane0;
  assign idx       = {2'b00, paddr[7:2]};
  assign mapped    = (paddr[1:0] == 2'h0) && known_idx(idx);
  assign lane0     = pstrb[0];
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !mapped;
  assign unlocked  = (unlock_cnt_reg != 3'h0);

  // write strobes per register
  assign wr_mode     = wr && is_reg(paddr, `IDX_MODE_CTRL);
  assign wr_level    = wr && is_reg(paddr, `IDX_WARN_LEVEL);
  assign wr_irq_ctrl = wr && is_reg(paddr, `IDX_IRQ_CTRL);
  assign wr_flag     = wr && is_reg(paddr, `IDX_IRQ_FLAG);
  assign wr_unlock   = wr && is_reg(paddr, `IDX_UNLOCK);

  // fuse copy while reset is held
  always @(posedge clk) begin
    if (rst) begin
      active_mode_reg    <= fuse_active_mode;
      threshold_code_reg <= fuse_threshold_code;
    end
  end

  // unlock window, closed by any mode write so one key opens one write
  always @* begin
    unlock_cnt_next = unlock_cnt_reg;
    if (wr_unlock && (pwdata[7:0] == `UNLOCK_KEY)) begin
      unlock_cnt_next = `UNLOCK_WINDOW;
    end else if (wr_mode) begin
      unlock_cnt_next = 3'h0;
    end else if (unlocked) begin
      unlock_cnt_next = unlock_cnt_reg - 3'h1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      unlock_cnt_reg <= 3'h0;
    end else begin
      unlock_cnt_reg <= unlock_cnt_next;
    end
  end

  // protected fields
  always @* begin
    sleep_mode_next         = sleep_mode_reg;
    sample_rate_select_next = sample_rate_select_reg;
    if (wr_mode && unlocked) begin
      if (pwdata[`POS_SLEEP_LO+1:`POS_SLEEP_LO] != `MODE_ON_STALL) begin
        sleep_mode_next = pwdata[`POS_SLEEP_LO+1:`POS_SLEEP_LO];
      end
      sample_rate_select_next = pwdata[`POS_SAMPLE_RATE];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      sleep_mode_reg         <= 2'h0;
      sample_rate_select_reg <= 1'b0;
      seen_reg               <= 1'b0;
    end else if (!seen_reg) begin
      sleep_mode_reg         <= fuse_sleep_mode;
      sample_rate_select_reg <= fuse_sample_rate;
      seen_reg               <= 1'b1;
    end else begin
      sleep_mode_reg         <= sleep_mode_next;
      sample_rate_select_reg <= sample_rate_select_next;
    end
  end

  // plain registers
  always @(posedge clk) begin
    if (rst) begin
      warning_margin_code_reg      <= `RST_WARN_LEVEL;
      warning_direction_select_reg <= `RST_DIR_SEL;
      warning_irq_enable_reg       <= `RST_IRQ_EN;
    end else begin
      if (wr_level) begin
        warning_margin_code_reg <= pwdata[1:0];
      end
      if (wr_irq_ctrl) begin
        warning_direction_select_reg <= pwdata[`POS_DIR_LO+1:`POS_DIR_LO];
        warning_irq_enable_reg       <= pwdata[`POS_IRQ_EN];
      end
    end
  end

  // operating mode selection
  assign cur_mode = deep_sleep ? sleep_mode_reg : active_mode_reg;
  assign mon_on   = seen_reg && (cur_mode != `MODE_OFF);
  assign mon_samp = seen_reg && (cur_mode == `MODE_SAMPLED);

  always @(posedge clk) begin
    if (rst) begin
      monitor_mode        <= `MODE_OFF;
      monitor_enable      <= 1'b0;
      monitor_sampled     <= 1'b0;
      threshold_code      <= 3'h0;
      warning_margin_code <= 2'h0;
      wake_stall          <= 1'b0;
    end else begin
      // mode stays off until the fuse copy is complete
      monitor_mode        <= seen_reg ? cur_mode : `MODE_OFF;
      monitor_enable      <= mon_on;
      monitor_sampled     <= mon_samp;
      threshold_code      <= threshold_code_reg;
      warning_margin_code <= warning_margin_code_reg;
      wake_stall          <= seen_reg && !deep_sleep &&
                             (active_mode_reg == `MODE_ON_STALL) &&
                             !monitor_ready;
    end
  end

  // sample rate divider
  sample_tick #(
    .FAST_CYCLES (FAST_CYCLES),
    .SLOW_CYCLES (SLOW_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .run  (mon_samp),
    .slow (sample_rate_select_reg),
    .tick (tick)
  );

  always @(posedge clk) begin
    if (rst) begin
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= tick;
    end
  end

  // comparator synchroniser
  level_sync3 u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (supply_below_warning),
    .dout (below_sync)
  );

  // warning follows the monitor mode
  assign take = mon_on && (!mon_samp || tick);
  assign fell = !warning_state_bit_reg && below_sync;
  assign rose = warning_state_bit_reg && !below_sync;

  always @* begin
    cross_hit = 1'b0;
    if (take) begin
      case (warning_direction_select_reg)
        `DIR_FALLING: cross_hit = fell && !mon_samp;
        `DIR_RISING:  cross_hit = rose;
        `DIR_EITHER:  cross_hit = (fell || rose) && !mon_samp;
        default:      cross_hit = 1'b0;
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      warning_state_bit_reg <= `RST_STATE;
    end else if (take) begin
      warning_state_bit_reg <= below_sync;
    end
  end

  // flag: set wins over clear
  always @* begin
    warning_irq_flag_next = warning_irq_flag_reg;
    if (wr_flag && pwdata[`POS_IRQ_FLAG]) begin
      warning_irq_flag_next = 1'b0;
    end
    if (cross_hit) begin
      warning_irq_flag_next = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      warning_irq_flag_reg <= `RST_FLAG;
      warning_irq         <= 1'b0;
    end else begin
      warning_irq_flag_reg <= warning_irq_flag_next;
      warning_irq         <= warning_irq_flag_next && warning_irq_enable_reg;
    end
  end

  // read word assembly; unaligned or unmapped reads give zero
  always @* begin
    rdata_next = 32'h00000000;
    if (paddr[1:0] == 2'h0) begin
      case (idx)
        `IDX_MODE_CTRL: begin
          rdata_next[`POS_SAMPLE_RATE]                = sample_rate_select_reg;
          rdata_next[`POS_ACTIVE_LO+1:`POS_ACTIVE_LO] = active_mode_reg;
          rdata_next[`POS_SLEEP_LO+1:`POS_SLEEP_LO]   = sleep_mode_reg;
        end
        `IDX_THRESHOLD: begin
          rdata_next[2:0] = threshold_code_reg;
        end
        `IDX_WARN_LEVEL: begin
          rdata_next[1:0] = warning_margin_code_reg;
        end
        `IDX_IRQ_CTRL: begin
          rdata_next[`POS_DIR_LO+1:`POS_DIR_LO] = warning_direction_select_reg;
          rdata_next[`POS_IRQ_EN]               = warning_irq_enable_reg;
        end
        `IDX_IRQ_FLAG: begin
          rdata_next[`POS_IRQ_FLAG] = warning_irq_flag_reg;
        end
        `IDX_WARN_STATE: begin
          rdata_next[`POS_STATE] = warning_state_bit_reg;
        end
        `IDX_UNLOCK: begin
          rdata_next[0] = unlocked;
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  // read data captured in the setup cycle
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rdata_next;
    end
  end

endmodule // brownout_monitor_control

// ===== verilog/brownout_consts.vh
`ifndef BROWNOUT_CONSTS_VH
`define BROWNOUT_CONSTS_VH

// register indices, byte address is four times the index
`define IDX_MODE_CTRL      8'h00
`define IDX_THRESHOLD      8'h01
`define IDX_WARN_LEVEL     8'h08
`define IDX_IRQ_CTRL       8'h09
`define IDX_IRQ_FLAG       8'h0A
`define IDX_WARN_STATE     8'h0B
`define IDX_UNLOCK         8'h0C

// field positions
`define POS_SAMPLE_RATE    4
`define POS_ACTIVE_LO      2
`define POS_SLEEP_LO       0
`define POS_DIR_LO         1
`define POS_IRQ_EN         0
`define POS_IRQ_FLAG       0
`define POS_STATE          0

// mode codes
`define MODE_OFF           2'h0
`define MODE_ON            2'h1
`define MODE_SAMPLED       2'h2
`define MODE_ON_STALL      2'h3

// direction codes
`define DIR_FALLING        2'h0
`define DIR_RISING         2'h1
`define DIR_EITHER         2'h2

// reset values
`define RST_WARN_LEVEL     2'h0
`define RST_IRQ_CTRL       3'h0
`define RST_DIR_SEL        2'h0
`define RST_IRQ_EN         1'h0
`define RST_FLAG           1'h0
`define RST_STATE          1'h0

// unlock key and open window in clock cycles
`define UNLOCK_KEY         8'hA5
`define UNLOCK_WINDOW      3'h4

// timing
`define CLK_HZ             20000000
`define SAMPLE_FAST_HZ     1000
`define SAMPLE_SLOW_HZ     125
`define SAMPLE_FAST_CYCLES (`CLK_HZ / `SAMPLE_FAST_HZ)
`define SAMPLE_SLOW_CYCLES (`CLK_HZ / `SAMPLE_SLOW_HZ)

`endif

// ===== verilog/level_sync3.v
module level_sync3 (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // asynchronous level in, settled level out
  input  wire din,
  output reg  dout
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end

endmodule // level_sync3

// ===== verilog/sample_tick.v
module sample_tick #(
  parameter FAST_CYCLES = 20000,
  parameter SLOW_CYCLES = 160000
) (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // control
  input  wire run,
  input  wire slow,
  // one-cycle enable
  output reg  tick
);

  reg  [17:0] cnt_reg;
  wire [17:0] last;

  assign last = slow ? SLOW_CYCLES[17:0] - 18'h00001 : FAST_CYCLES[17:0] - 18'h00001;

  always @(posedge clk) begin
    if (rst || !run) begin
      cnt_reg <= 18'h00000;
      tick    <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= 18'h00000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 18'h00001;
      tick    <= 1'b0;
    end
  end

endmodule // sample_tick

// ===== verif/brownout_monitor_control_monitor.sv
module bmc_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // bus and power
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       deep_sleep,
  input wire logic       monitor_ready,
  // monitor outputs
  input wire logic [1:0] monitor_mode,
  input wire logic       monitor_enable,
  input wire logic       monitor_sampled,
  input wire logic       sample_strobe,
  input wire logic [2:0] threshold_code,
  input wire logic       wake_stall,
  input wire logic       warning_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] up_reg;
  always @(posedge clk) begin
    if (rst)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  end
  sequence s_write;
    $past(psel && penable && pwrite, 1) || $past(psel && penable && pwrite, 2);
  endsequence
  sequence s_awake;
    !deep_sleep && !$past(deep_sleep);
  endsequence
  property p_enable;
    monitor_enable == (monitor_mode != 2'h0);
  endproperty
  a_enable: assert property (p_enable) else $error("enable off mode");
  property p_sampled;
    monitor_sampled == (monitor_mode == 2'h2);
  endproperty
  a_sampled: assert property (p_sampled) else $error("sampled off mode");
  property p_strobe_mode;
    sample_strobe |-> monitor_sampled || $past(monitor_sampled);
  endproperty
  a_strobe_mode: assert property (p_strobe_mode) else $error("strobe not sampled");
  property p_strobe_pulse;
    sample_strobe |=> !sample_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_stall;
    wake_stall |-> !$past(deep_sleep) && !$past(monitor_ready);
  endproperty
  a_stall: assert property (p_stall) else $error("stall without cause");
  property p_active_hold;
    (up_reg == 2'h3) ##0 s_awake |=> $stable(monitor_mode);
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("awake mode moved");
  property p_threshold;
    up_reg == 2'h3 |-> $stable(threshold_code);
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold moved");
  property p_irq_fall;
    $fell(warning_irq) && up_reg == 2'h3 |-> s_write;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule // bmc_checker

bind brownout_monitor_control bmc_checker bmc_checker_i (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .deep_sleep(deep_sleep),
  .monitor_ready(monitor_ready), .monitor_mode(monitor_mode),
  .monitor_enable(monitor_enable), .monitor_sampled(monitor_sampled),
  .sample_strobe(sample_strobe), .threshold_code(threshold_code),
  .wake_stall(wake_stall), .warning_irq(warning_irq));

// ===== verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        deep_sleep = 0, monitor_ready = 1, supply_below_warning = 0;
  logic        fuse_sample_rate = 0, serr = 0;
  logic [7:0]  paddr = 8'h00, rdat;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [1:0]  fuse_active_mode = 2'h1, fuse_sleep_mode = 2'h2;
  logic [2:0]  fuse_threshold_code = 3'h2;
  // observed
  wire         pready, pslverr, monitor_enable, monitor_sampled, sample_strobe;
  wire         wake_stall, warning_irq;
  wire  [31:0] prdata;
  wire  [1:0]  monitor_mode, warning_margin_code;
  wire  [2:0]  threshold_code;
  int          fail_count = 0, cmp_count = 0;

  brownout_monitor_control #(.FAST_CYCLES(8), .SLOW_CYCLES(20)) brownout_monitor_control_i (.*);

  always #25 clk = ~clk;

  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata[7:0];
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, e);
    apb(1'b0, a, 8'h00);
    chk(rdat, e);
  endtask

  task automatic unl_wr(input logic [7:0] d);
    wr(8'h30, 8'hA5);
    wr(8'h00, d);
  endtask

  task automatic t_reset;
    rd(8'h00, 8'h06);
    rd(8'h04, 8'h02);
    rd(8'h24, 8'h00);
    rd(8'h28, 8'h00);
    rd(8'h2C, 8'h00);
    rd(8'h08, 8'h00);
    chk({7'h0, serr}, 8'h01);
    rd(8'h20, 8'h00);
    chk({7'h0, serr}, 8'h00);
    chk({5'h0, threshold_code}, 8'h02);
  endtask

  task automatic t_protect;
    wr(8'h04, 8'h07);
    rd(8'h04, 8'h02);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h06);
    unl_wr(8'h1D);
    rd(8'h00, 8'h15);
    wr(8'h00, 8'h02);
    rd(8'h00, 8'h15);
    unl_wr(8'h13);
    rd(8'h00, 8'h15);
  endtask

  task automatic gap(input int n);
    int k;
    k = 0;
    while (sample_strobe !== 1'b1) @(posedge clk);
    do begin
      @(posedge clk);
      k++;
    end while (sample_strobe !== 1'b1);
    chk(k[7:0], n[7:0]);
  endtask

  task automatic t_sleep(input logic [7:0] mv, input int n);
    unl_wr(mv);
    rd(8'h00, mv | 8'h04);
    @(posedge clk);
    deep_sleep <= 1'b1;
    repeat (3) @(posedge clk);
    chk({6'h0, monitor_mode}, {6'h0, mv[1:0]});
    if (n > 0)
      gap(n);
    @(posedge clk);
    deep_sleep <= 1'b0;
    repeat (3) @(posedge clk);
    chk({6'h0, monitor_mode}, 8'h01);
    chk({7'h0, monitor_enable}, 8'h01);
  endtask

  task automatic t_warn;
    logic [1:0] d;
    for (int i = 0; i < 3; i++) begin
      d = i[1:0];
      wr(8'h24, {5'h0, d, 1'b1});
      wr(8'h28, 8'h01);
      @(posedge clk);
      supply_below_warning <= 1'b1;
      repeat (8) @(posedge clk);
      rd(8'h2C, 8'h01);
      rd(8'h28, {7'h0, d != 2'h1});
      chk({7'h0, warning_irq}, {7'h0, d != 2'h1});
      wr(8'h28, 8'h00);
      rd(8'h28, {7'h0, d != 2'h1});
      wr(8'h28, 8'h01);
      @(posedge clk);
      supply_below_warning <= 1'b0;
      repeat (8) @(posedge clk);
      rd(8'h2C, 8'h00);
      rd(8'h28, {7'h0, d != 2'h0});
    end
    wr(8'h24, 8'h04);
    repeat (2) @(posedge clk);
    chk({7'h0, warning_irq}, 8'h00);
    wr(8'h24, 8'h05);
    repeat (2) @(posedge clk);
    chk({7'h0, warning_irq}, 8'h01);
    wr(8'h28, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h0, warning_irq}, 8'h00);
  endtask

  task automatic t_margin;
    for (int m = 0; m < 3; m++) begin
      wr(8'h20, m[7:0]);
      rd(8'h20, m[7:0]);
      chk({6'h0, warning_margin_code}, m[7:0]);
    end
  endtask

  task automatic t_fuse(input logic [1:0] am);
    @(posedge clk);
    fuse_active_mode <= am;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({6'h0, monitor_mode}, {6'h0, am});
    chk({7'h0, monitor_sampled}, {7'h0, am == 2'h2});
    rd(8'h00, {4'h0, am, 2'h2});
    rd(8'h24, 8'h00);
    if (am == 2'h3) begin
      monitor_ready <= 1'b0;
      repeat (2) @(posedge clk);
      chk({7'h0, wake_stall}, 8'h01);
      monitor_ready <= 1'b1;
      repeat (2) @(posedge clk);
      chk({7'h0, wake_stall}, 8'h00);
    end else begin
      gap(8);
      wr(8'h24, 8'h01);
      supply_below_warning <= 1'b1;
      repeat (24) @(posedge clk);
      rd(8'h2C, 8'h01);
      rd(8'h28, 8'h00);
      wr(8'h24, 8'h03);
      supply_below_warning <= 1'b0;
      repeat (24) @(posedge clk);
      rd(8'h2C, 8'h00);
      rd(8'h28, 8'h01);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset;
    t_protect;
    t_sleep(8'h16, 20);
    t_sleep(8'h02, 8);
    t_margin;
    t_warn;
    t_fuse(2'h3);
    t_fuse(2'h2);
    report_and_stop;
  end

  initial begin
    #400000;
    fail_count++;
    report_and_stop;
  end
endmodule // tb
